// [tlip_pkg.sv]
/*
  Constants, register map and shared types of the two-level interrupt
  prioritizer.
  Assumes a core that reports instruction completion, key writes and
  interrupt returns as single-cycle pulses on the core clock.
*/
`default_nettype none

package tlip_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_VEC   = 32;
  localparam int unsigned VEC_W     = 8;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned ADDR_W    = 2;
  localparam int unsigned PC_W      = 16;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [1:0] OFS_VECTOR_CONTROL   = 2'h0;
  localparam logic [1:0] OFS_EXEC_LEVEL_FLAGS = 2'h1;
  localparam logic [1:0] OFS_NORMAL_LAST      = 2'h2;
  localparam logic [1:0] OFS_HIGH_VECTOR      = 2'h3;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_VECTOR_TABLE_SELECT = 6;
  localparam int unsigned BIT_COMPACT_TABLE       = 5;
  localparam int unsigned BIT_ROUND_ROBIN         = 0;
  localparam int unsigned BIT_NMI_EXEC            = 7;
  localparam int unsigned BIT_HIGH_EXEC           = 1;
  localparam int unsigned BIT_NORMAL_EXEC         = 0;
  localparam logic [7:0]  RST_VECTOR_CONTROL      = 8'h00;
  localparam logic [7:0]  RST_NORMAL_LAST         = 8'h00;
  localparam logic [7:0]  RST_HIGH_VECTOR         = 8'h00;

  // ----------------------------------------------------------------------
  // Vectors and protection window
  // ----------------------------------------------------------------------
  // Fixed set of non-maskable lines; vector 0 is the reset vector
  localparam logic [31:0] NMI_LINES         = 32'h0000_0002;
  localparam logic [7:0]  COMPACT_NMI_VEC    = 8'h01;
  localparam logic [7:0]  COMPACT_HIGH_VEC   = 8'h02;
  localparam logic [7:0]  COMPACT_NORMAL_VEC = 8'h03;
  localparam logic [7:0]  NO_HIGH_VEC       = 8'h00;
  localparam logic [2:0]  KEY_WINDOW_INSTR  = 3'h4;
  localparam logic [15:0] BOOT_START_ADDR   = 16'h0000;

  typedef struct packed {
    logic             found;
    logic [IDX_W-1:0] idx;
  } tlip_pick_s;

endpackage

`default_nettype wire

// [tlip_top.sv]
/*
  Two-level interrupt prioritizer: register file, key-protected control
  bits, priority arbitration, executing-level tracking and vector output.
  Assumes peripheral request lines held high until cleared by software,
  and a core that pulses instr_done, key_write and return_from_interrupt.
*/
// Decided for this implementation: the plain strobed port.
// Notes on behaviour
// R1: Sources default level 0; one chosen source level 1
// R2: Level 1 preempts level 0; level 0 resumes after
// R3: Non-maskable taken regardless of global enable
// R4: Nothing preempts a running non-maskable handler
// R5: Several non-maskable pending: lowest vector wins
// R6: Software enables non-maskable sources at the peripheral
// R7: Round robin off: lowest level 0 vector wins
// R8: Round robin on: last served level 0 lowest
// R9: Compact table: vectors 1, 2 and 3 only
// R10: Protected write needs key within four instructions
// R11: Table select and compact bits protected; round robin free
// R12: Table select picks application or boot start
// R13: Bit 7 shows non-maskable executing, cleared by return
// R14: Bit 1 shows level 1 executing, cleared by return
// R15: Bit 0 shows level 0 executing, cleared by return
// R16: Last served register tracks acknowledged level 0 vector, only while round robin is on
// R17: Reset clears round-robin state
// R18: High vector zero disables level 1
// R19: One instruction between two acknowledgements
// R20: Acknowledge never touches global interrupt enable
// R21: Blocked requests stay pending until they can win
`timescale 1ns/10ps
`default_nettype none

module tlip_top
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Peripheral requests, bit n is vector n
  input  wire logic [31:0] irq_req,
  // Core side
  input  wire logic        global_int_enable,
  input  wire logic        instr_done,
  input  wire logic        key_write,
  input  wire logic        return_from_interrupt,
  input  wire logic [7:0]  boot_end_setting,
  output logic             int_take,
  output logic      [7:0]  int_vector,
  output logic      [15:0] int_target
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        table_select;
    logic        compact_table;
    logic        round_robin;
    logic        nmi_exec;
    logic        high_exec;
    logic        normal_exec;
    logic [7:0]  last_served;
    logic [7:0]  high_vector;
    logic [2:0]  key_cnt;
    logic        instr_seen;
    logic        take;
    logic [7:0]  vector;
    logic [15:0] target;
    logic [7:0]  rdata;
  } tlip_state_s;

  tlip_state_s st_ff;
  tlip_state_s nxt_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Circular search from start; start 0 gives plain lowest-first
  function automatic tlip_pkg::tlip_pick_s pick_from
  (
    input logic [31:0]               req,
    input logic [tlip_pkg::IDX_W-1:0] start
  );
    tlip_pkg::tlip_pick_s    res;
    logic [tlip_pkg::IDX_W-1:0] j;
    res = '0;
    for (int i = tlip_pkg::NUM_VEC - 1; i >= 0; i--)
    begin
      j = start + tlip_pkg::IDX_W'(i);
      if (req[j])
      begin
        res.found = 1'b1;
        res.idx   = j;
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] status_byte
  (
    input logic nmi,
    input logic high,
    input logic normal
  );
    logic [7:0] b;
    b = 8'h00;
    b[tlip_pkg::BIT_NMI_EXEC]    = nmi;
    b[tlip_pkg::BIT_HIGH_EXEC]   = high;
    b[tlip_pkg::BIT_NORMAL_EXEC] = normal;
    return b;
  endfunction

  // Slot used in the table: the shared short slot when compacted
  function automatic logic [7:0] table_slot
  (
    input logic       compact,
    input logic [7:0] full_vec,
    input logic [7:0] short_vec
  );
    return compact ? short_vec : full_vec;
  endfunction

  // ----------------------------------------------------------------------
  // Classification and arbitration
  // ----------------------------------------------------------------------
  logic [31:0]               req_valid;
  logic [31:0]               nmi_req;
  logic [31:0]               high_req;
  logic [31:0]               normal_req;
  logic [31:0]               high_mask;
  logic                      high_enabled;
  logic                      high_blocked;
  logic                      normal_blocked;
  logic [tlip_pkg::IDX_W-1:0] rr_start;
  tlip_pkg::tlip_pick_s      nmi_pick;
  tlip_pkg::tlip_pick_s      normal_pick;
  logic                      nmi_win;
  logic                      high_win;
  logic                      normal_win;
  logic                      can_take;

  always_comb
  begin
    // Vector 0 is the reset vector and never requests
    req_valid    = irq_req & ~32'h0000_0001;
    nmi_req      = req_valid & tlip_pkg::NMI_LINES;
    high_enabled = (st_ff.high_vector != tlip_pkg::NO_HIGH_VEC);       // [R18]
    high_mask    = '0;
    // Values of 32 and up match no source, so level 1 stays off
    if (high_enabled && st_ff.high_vector < 8'(tlip_pkg::NUM_VEC))
    begin
      high_mask[st_ff.high_vector[tlip_pkg::IDX_W-1:0]] = 1'b1;        // [R1]
    end
    high_req     = req_valid & high_mask & ~tlip_pkg::NMI_LINES;
    normal_req   = req_valid & ~high_mask & ~tlip_pkg::NMI_LINES;      // [R1]
    // Round robin starts one past the last served, making it last
    if (st_ff.round_robin)
    begin
      rr_start = st_ff.last_served[tlip_pkg::IDX_W-1:0] +
                 tlip_pkg::IDX_W'(1);                                  // [R8]
    end
    else
    begin
      rr_start = '0;                                                   // [R7]
    end
    nmi_pick     = pick_from(nmi_req, '0);                             // [R5]
    normal_pick  = pick_from(normal_req, rr_start);                    // [R7] [R8]

    // A level enters only when nothing at or above it executes
    high_blocked   = st_ff.nmi_exec || st_ff.high_exec;                // [R4]
    normal_blocked = high_blocked || st_ff.normal_exec;                // [R4]

    // Executing level gates what may preempt; losers stay pending
    nmi_win    = nmi_pick.found && !st_ff.nmi_exec;                    // [R3] [R4]
    high_win   = !nmi_win && (|high_req) && global_int_enable &&
                 !high_blocked;                                        // [R2] [R21]
    normal_win = !nmi_win && !high_win && normal_pick.found &&
                 global_int_enable && !normal_blocked;                 // [R21]

    // Holding off while take is high keeps take a one-cycle pulse
    can_take   = instr_done && st_ff.instr_seen && !st_ff.take;        // [R19]
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [7:0]  win_vec;
  logic [7:0]  out_vec;
  logic [15:0] table_base;
  logic        key_open;
  logic        accept;

  always_comb
  begin
    nxt_st     = st_ff;
    win_vec    = 8'h00;
    out_vec    = 8'h00;
    key_open   = (st_ff.key_cnt != 3'h0);
    accept     = can_take && (nmi_win || high_win || normal_win);

    // Boot start when selected, otherwise the application start
    if (st_ff.table_select)
    begin
      table_base = tlip_pkg::BOOT_START_ADDR;                          // [R12]
    end
    else
    begin
      table_base = {boot_end_setting, 8'h00};                          // [R12]
    end

    // Key window counts instructions after the key write
    if (key_write)
    begin
      nxt_st.key_cnt = tlip_pkg::KEY_WINDOW_INSTR;                     // [R10]
    end
    else if (key_open && instr_done)
    begin
      nxt_st.key_cnt = st_ff.key_cnt - 3'h1;                           // [R10]
    end

    // Arms the next take once an instruction has retired
    if (instr_done)
    begin
      nxt_st.instr_seen = 1'b1;
    end

    // Return ends the innermost executing level
    if (return_from_interrupt)
    begin
      if (st_ff.nmi_exec)
      begin
        nxt_st.nmi_exec = 1'b0;                                        // [R13]
      end
      else if (st_ff.high_exec)
      begin
        nxt_st.high_exec = 1'b0;                                       // [R14]
      end
      else
      begin
        nxt_st.normal_exec = 1'b0;                                     // [R15]
      end
    end

    // Software writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        tlip_pkg::OFS_VECTOR_CONTROL:
        begin
          nxt_st.round_robin =
            reg_wdata[tlip_pkg::BIT_ROUND_ROBIN];                      // [R11]
          if (key_open)
          begin
            nxt_st.table_select =
              reg_wdata[tlip_pkg::BIT_VECTOR_TABLE_SELECT];            // [R10] [R11]
            nxt_st.compact_table =
              reg_wdata[tlip_pkg::BIT_COMPACT_TABLE];                  // [R10] [R11]
          end
        end
        tlip_pkg::OFS_NORMAL_LAST:
        begin
          nxt_st.last_served = reg_wdata;                              // [R16]
        end
        tlip_pkg::OFS_HIGH_VECTOR:
        begin
          nxt_st.high_vector = reg_wdata;                              // [R1]
        end
        default:
        begin
          nxt_st.high_vector = st_ff.high_vector;
        end
      endcase
    end

    // Acknowledge; global enable is only read, never written here
    nxt_st.take = accept;                                              // [R20]
    if (accept)
    begin
      nxt_st.instr_seen = 1'b0;                                        // [R19]
      if (nmi_win)
      begin
        win_vec         = 8'(nmi_pick.idx);
        out_vec         = table_slot(st_ff.compact_table, win_vec,
                                     tlip_pkg::COMPACT_NMI_VEC);       // [R9]
        nxt_st.nmi_exec = 1'b1;                                        // [R3] [R13]
      end
      else if (high_win)
      begin
        win_vec          = st_ff.high_vector;
        out_vec          = table_slot(st_ff.compact_table, win_vec,
                                      tlip_pkg::COMPACT_HIGH_VEC);     // [R9]
        nxt_st.high_exec = 1'b1;                                       // [R2] [R14]
      end
      else
      begin
        win_vec            = 8'(normal_pick.idx);
        out_vec            = table_slot(st_ff.compact_table, win_vec,
                                        tlip_pkg::COMPACT_NORMAL_VEC); // [R9]
        nxt_st.normal_exec = 1'b1;                                     // [R15]
        // Hardware update wins over a same-cycle software write
        if (st_ff.round_robin)
        begin
          nxt_st.last_served = win_vec;                                // [R8] [R16]
        end
      end
      nxt_st.vector = out_vec;                                         // [R9]
      nxt_st.target = table_base + {8'h00, out_vec};                   // [R12]
    end

    // Read data valid only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        tlip_pkg::OFS_VECTOR_CONTROL:
        begin
          nxt_st.rdata[tlip_pkg::BIT_VECTOR_TABLE_SELECT] =
            st_ff.table_select;
          nxt_st.rdata[tlip_pkg::BIT_COMPACT_TABLE] = st_ff.compact_table;
          nxt_st.rdata[tlip_pkg::BIT_ROUND_ROBIN]   = st_ff.round_robin;
        end
        tlip_pkg::OFS_EXEC_LEVEL_FLAGS:
        begin
          nxt_st.rdata = status_byte(st_ff.nmi_exec, st_ff.high_exec,
                                     st_ff.normal_exec);               // [R13] [R14] [R15]
        end
        tlip_pkg::OFS_NORMAL_LAST:
        begin
          nxt_st.rdata = st_ff.last_served;                            // [R16]
        end
        default:
        begin
          nxt_st.rdata = st_ff.high_vector;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff               <= '0;
      st_ff.table_select  <=
        tlip_pkg::RST_VECTOR_CONTROL[tlip_pkg::BIT_VECTOR_TABLE_SELECT];
      st_ff.compact_table <=
        tlip_pkg::RST_VECTOR_CONTROL[tlip_pkg::BIT_COMPACT_TABLE];
      st_ff.round_robin   <=
        tlip_pkg::RST_VECTOR_CONTROL[tlip_pkg::BIT_ROUND_ROBIN];
      st_ff.last_served   <= tlip_pkg::RST_NORMAL_LAST;                // [R17]
      st_ff.high_vector   <= tlip_pkg::RST_HIGH_VECTOR;                // [R18]
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata  = st_ff.rdata;
  assign int_take   = st_ff.take;
  assign int_vector = st_ff.vector;
  assign int_target = st_ff.target;

endmodule

`default_nettype wire

// [tlip_core_model.sv]
/*
  Core stand-in: one instruction completes every second cycle.
  Assumes the bench drives run and core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tlip_core_model
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic run,
  output logic      instr_done
);
  // Two-cycle instructions keep key window counts easy to predict
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      instr_done <= 1'b0;
    else
      instr_done <= run & ~instr_done;
endmodule

`default_nettype wire

// [tlip_chk.sv]
/*
  Port checker for tlip_top, bound below.
  Assumes a single clock domain with async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module tlip_chk
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [1:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [31:0] irq_req,
  input wire logic        global_int_enable,
  input wire logic        instr_done,
  input wire logic        int_take,
  input wire logic [7:0]  int_vector,
  input wire logic [15:0] int_target
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_take_pulse: assert property (int_take |=> !int_take)
    else $error("take longer than one cycle");
  a_take_on_instr: assert property (int_take |-> $past(instr_done))
    else $error("take without instruction boundary");
  a_take_has_req: assert property (int_take |-> $past(|irq_req[31:1]))
    else $error("take without request");
  a_take_masked: assert property (int_take && int_vector != 8'h01
    |-> $past(global_int_enable)) else $error("maskable taken while off");
  a_vec_range: assert property (int_take |-> int_vector inside
    {[8'h01:8'h1f]}) else $error("vector out of range");
  a_vec_hold: assert property (!int_take
    |-> $stable(int_vector) && $stable(int_target))
    else $error("vector moved without take");
  a_status_spare: assert property ($past(reg_rd && reg_addr == 2'h1)
    |-> reg_rdata[6:2] == 5'h00) else $error("status spare bits set");
  a_ctrl_spare: assert property ($past(reg_rd && reg_addr == 2'h0)
    |-> reg_rdata[7] == 1'b0 && reg_rdata[4:1] == 4'h0)
    else $error("control spare bits set");
endmodule

bind tlip_top tlip_chk i_tlip_chk (.core_clk(core_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_req(irq_req), .global_int_enable(global_int_enable),
  .instr_done(instr_done), .int_take(int_take), .int_vector(int_vector),
  .int_target(int_target));

`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for tlip_top.
  Assumes the core model retires an instruction every second cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        core_clk, arst_n, reg_wr, reg_rd, gie, run, key, ret_p;
  logic        instr_done, int_take;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, int_vector, boot_end;
  logic [31:0] irq_req;
  logic [15:0] int_target;
  int          fail_count, compares;

  always #4 core_clk = ~core_clk;

  tlip_top i_tlip_top (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
    .global_int_enable(gie), .instr_done(instr_done), .key_write(key),
    .return_from_interrupt(ret_p), .boot_end_setting(boot_end),
    .int_take(int_take), .int_vector(int_vector), .int_target(int_target));
  tlip_core_model i_tlip_core_model (.core_clk(core_clk), .arst_n(arst_n),
    .run(run), .instr_done(instr_done));

  // ----
  // Shared tasks
  // ----
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] g, e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check("rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic ret(input logic [31:0] req_left);
    @(posedge core_clk);
    irq_req <= req_left;
    ret_p   <= 1'b1;
    @(posedge core_clk);
    ret_p <= 1'b0;
  endtask

  task automatic key_pulse();
    @(posedge core_clk);
    key <= 1'b1;
    @(posedge core_clk);
    key <= 1'b0;
  endtask

  // Bounded wait for an acknowledge, then vector and target compare
  task automatic wait_take(input logic [7:0] v, input logic [15:0] t);
    int i;
    i = 0;
    do
    begin
      @(negedge core_clk);
      i++;
    end
    while (i < 40 && int_take !== 1'b1);
    if (int_take !== 1'b1)
    begin
      check("take", 16'h0000, 16'h0001);
      final_report();
    end
    check("vector", {8'h00, int_vector}, {8'h00, v});
    check("target", int_target, t);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h00);
  endtask

  task automatic t_levels();
    @(posedge core_clk);
    gie     <= 1'b1;
    irq_req <= 32'h0000_0220;
    wait_take(8'h05, 16'h1205);
    rd(2'h1, 8'h01);
    wr(2'h3, 8'h09);
    wait_take(8'h09, 16'h1209);
    rd(2'h1, 8'h03);
    ret(32'h0000_0020);
    rd(2'h1, 8'h01);
    ret(32'h0000_0000);
    rd(2'h1, 8'h00);
    wr(2'h3, 8'h00);
  endtask

  task automatic t_nmi();
    @(posedge core_clk);
    gie      <= 1'b0;
    boot_end <= 8'h34;
    irq_req  <= 32'h0000_0022;
    wait_take(8'h01, 16'h3401);
    rd(2'h1, 8'h80);
    @(posedge core_clk);
    gie <= 1'b1;
    repeat (20)
    begin
      @(negedge core_clk);
      check("take", {15'h0, int_take}, 16'h0000);
    end
    ret(32'h0000_0020);
    wait_take(8'h05, 16'h3405);
    rd(2'h1, 8'h01);
    ret(32'h0000_0000);
    boot_end <= 8'h12;
  endtask

  task automatic t_rr();
    wr(2'h0, 8'h01);
    @(posedge core_clk);
    irq_req <= 32'h0000_0028;
    wait_take(8'h03, 16'h1203);
    ret(32'h0000_0028);
    wait_take(8'h05, 16'h1205);
    rd(2'h2, 8'h05);
    ret(32'h0000_0028);
    wait_take(8'h03, 16'h1203);
    rd(2'h2, 8'h03);
    ret(32'h0000_0000);
  endtask

  task automatic t_key();
    wr(2'h0, 8'h60);
    rd(2'h0, 8'h00);
    key_pulse();
    wr(2'h0, 8'h61);
    rd(2'h0, 8'h61);
    key_pulse();
    // Six instructions retire, so the window has closed
    repeat (12) @(posedge core_clk);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h60);
  endtask

  task automatic t_compact();
    @(posedge core_clk);
    irq_req <= 32'h0000_0082;
    wait_take(8'h01, 16'h0001);
    wr(2'h3, 8'h07);
    ret(32'h0000_0180);
    wait_take(8'h02, 16'h0002);
    ret(32'h0000_0100);
    wait_take(8'h03, 16'h0003);
    ret(32'h0000_0000);
  endtask

  initial
  begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    {reg_wr, reg_rd, gie, run, key, ret_p} = 6'h00;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    boot_end = 8'h12;
    irq_req = 32'h0;
    fail_count = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    run    <= 1'b1;
    t_reset();
    t_levels();
    t_nmi();
    t_rr();
    t_key();
    t_compact();
    final_report();
  end
endmodule

`default_nettype wire
